//--- logic/ahthr_pkg.sv
package ahthr_pkg;

    // ------------------------------------------------------------
    // widths and channel counts
    // ------------------------------------------------------------
    localparam int ADDR_W   = 8;                  // register address width
    localparam int DATA_W   = 8;                  // register data width
    localparam int THR_W    = 14;                 // alarm threshold width
    localparam int HYST_W   = 6;                  // hysteresis code width
    localparam int MAX_CH   = 8;                  // largest variant
    localparam int CH_W     = 3;                  // channel index width
    localparam int SEL_W    = 3;                  // byte select width
    localparam int FIELD_LSB = 2;                 // lowest writable bit of the 6-bit fields

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CH0_HYST_ADDR = 8'h15;   // ch0_alarm_hysteresis
    localparam logic [ADDR_W-1:0] CH0_HTU_ADDR  = 8'h16;   // ch0_high_threshold_upper
    localparam logic [ADDR_W-1:0] CH0_HTL_ADDR  = 8'h17;   // ch0_high_threshold_lower
    localparam logic [ADDR_W-1:0] CH_STRIDE     = 8'h05;   // bytes per channel set
    localparam logic [ADDR_W-1:0] MAP_END       = 8'h3d;   // first address past channel 7
    localparam logic [SEL_W-1:0]  SEL_HYST      = 3'h0;    // byte 0 of a set
    localparam logic [SEL_W-1:0]  SEL_HTU       = 3'h1;    // byte 1 of a set
    localparam logic [SEL_W-1:0]  SEL_HTL       = 3'h2;    // byte 2 of a set

    // ------------------------------------------------------------
    // reset values and read answers
    // ------------------------------------------------------------
    localparam logic [HYST_W-1:0] HYST_RST      = 6'h00;
    localparam logic [DATA_W-1:0] HTU_RST       = 8'h01;
    localparam logic [HYST_W-1:0] HTL_RST       = 6'h01;
    localparam logic [1:0]        LOW_BITS_ZERO = 2'h0;
    localparam logic [DATA_W-1:0] READ_ABSENT   = 8'hff;   // channel missing in this variant
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;   // address not held by this block

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [THR_W-1:0]  high_thr;      // 14-bit high alarm threshold
        logic [HYST_W-1:0] hyst;          // shared by high and low alarm
        logic [THR_W-1:0]  high_release;  // level where a high alarm clears
    } ahthr_alarm_t;

    typedef struct packed {
        logic             hit;            // address belongs to this block
        logic [CH_W-1:0]  ch;             // channel index
        logic [SEL_W-1:0] sel;            // byte within the set
    } ahthr_dec_t;

endpackage

//--- logic/ahthr_chan.sv
`timescale 1ns/1ps
module ahthr_chan
    import ahthr_pkg::*;
(
    // clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // byte write from the decoder
    input  wire logic                      wr_i,
    input  wire logic [SEL_W-1:0]          sel_i,
    input  wire logic [DATA_W-1:0]         wdata_i,
    // read data and settings toward the comparator
    output logic      [DATA_W-1:0]         rdata_o,
    output ahthr_alarm_t                   alarm_o
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [HYST_W-1:0] hyst_reg;      // hysteresis code
    logic [HYST_W-1:0] hyst_next;
    logic [DATA_W-1:0] htu_reg;       // threshold bits 13:6
    logic [DATA_W-1:0] htu_next;
    logic [HYST_W-1:0] htl_reg;       // threshold bits 5:0
    logic [HYST_W-1:0] htl_next;
    logic [THR_W-1:0]  rel_reg;       // release level
    logic [THR_W-1:0]  rel_next;

    // a code n moves the release point by exactly n lsb, floored at zero
    function automatic logic [THR_W-1:0] release_level(input logic [THR_W-1:0] thr,
                                                        input logic [HYST_W-1:0] hy);
        logic [THR_W-1:0] hy_w;
        hy_w = {{(THR_W-HYST_W){1'b0}}, hy};
        if (thr >= hy_w) begin
            release_level = thr - hy_w;
        end else begin
            release_level = '0;
        end
    endfunction

    // ------------------------------------------------------------
    // next values: one byte changes per write
    // ------------------------------------------------------------
    always_comb begin
        hyst_next = hyst_reg;
        htu_next  = htu_reg;
        htl_next  = htl_reg;
        if (wr_i) begin
            unique case (sel_i)
                SEL_HYST: hyst_next = wdata_i[DATA_W-1:FIELD_LSB];
                SEL_HTU:  htu_next  = wdata_i;
                SEL_HTL:  htl_next  = wdata_i[DATA_W-1:FIELD_LSB];
                default:  hyst_next = hyst_reg;                     // bytes of the low threshold
            endcase
        end
        // computed from the next bytes so the release never lags the threshold
        rel_next = release_level({htu_next, htl_next}, hyst_next);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hyst_reg <= HYST_RST;
            htu_reg  <= HTU_RST;
            htl_reg  <= HTL_RST;
            rel_reg  <= release_level({HTU_RST, HTL_RST}, HYST_RST);
        end else begin
            // all fields land on the same edge, so a write is atomic
            hyst_reg <= hyst_next;
            htu_reg  <= htu_next;
            htl_reg  <= htl_next;
            rel_reg  <= rel_next;
        end
    end

    // ------------------------------------------------------------
    // read mux and outputs
    // ------------------------------------------------------------
    always_comb begin
        unique case (sel_i)
            SEL_HYST: rdata_o = {hyst_reg, LOW_BITS_ZERO};
            SEL_HTU:  rdata_o = htu_reg;
            SEL_HTL:  rdata_o = {htl_reg, LOW_BITS_ZERO};
            default:  rdata_o = READ_UNMAPPED;
        endcase
    end

    assign alarm_o.high_thr     = {htu_reg, htl_reg};
    assign alarm_o.hyst         = hyst_reg;
    assign alarm_o.high_release = rel_reg;

endmodule

//--- logic/ahthr_regs.sv
`timescale 1ns/1ps
// Operation
// - per-channel hysteresis in bits seven to two
// - code zero none, code n is n LSB
// - hysteresis steps linearly between the end codes
// - channel zero set at 15h, 16h, 17h
// - hysteresis clears to zero on reset
// - upper byte is threshold bits thirteen to six
// - any upper byte value stored as written
// - upper byte resets to one
// - lower byte bits seven-two are threshold LSBs
// - lower field resets to one, low bits zero
// - bits one and zero read zero, ignore writes
// - threshold is upper byte then six-bit field
// - one hysteresis serves high and low alarms
// - absent channels ignore writes, read all ones
module ahthr_regs
    import ahthr_pkg::*;
#(
    parameter int NUM_CH = MAX_CH                    // 8 or 4
)(
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // register port from the serial frame logic
    input  wire logic                        reg_wr_i,
    input  wire logic                        reg_rd_i,
    input  wire logic [ADDR_W-1:0]           reg_addr_i,
    input  wire logic [DATA_W-1:0]           reg_wdata_i,
    // read answer
    output logic      [DATA_W-1:0]           reg_rdata_o,
    output logic                             reg_rvalid_o,
    output logic                             reg_hit_o,
    // settings toward the alarm comparator
    output ahthr_alarm_t                     alarm_o [NUM_CH]
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // channel sets repeat every five bytes; bytes 3 and 4 are the low threshold
    function automatic ahthr_dec_t decode(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        decode = '0;
        off    = a - CH0_HYST_ADDR;
        if (a >= CH0_HYST_ADDR && a < MAP_END) begin
            decode.ch  = CH_W'(off / CH_STRIDE);
            decode.sel = SEL_W'(off % CH_STRIDE);
            decode.hit = (decode.sel <= SEL_HTL);
        end
    endfunction

    ahthr_dec_t        dec;                          // decode of the current address
    logic              absent;                       // channel not built in this variant
    logic [DATA_W-1:0] chan_rdata [NUM_CH];          // per-channel read mux
    logic [DATA_W-1:0] sel_rdata;                    // selected channel byte
    logic [DATA_W-1:0] rdata_reg;
    logic              rvalid_reg;

    assign dec       = decode(reg_addr_i);
    assign absent    = dec.hit && (int'(dec.ch) >= NUM_CH);
    assign reg_hit_o = dec.hit;

    // ------------------------------------------------------------
    // channel sets
    // ------------------------------------------------------------
    // only the built channels get storage, so absent ones cannot be written
    for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
        logic ch_wr;
        assign ch_wr = reg_wr_i && dec.hit && (dec.ch == CH_W'(n));
        ahthr_chan u_chan (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .wr_i    (ch_wr),
            .sel_i   (dec.sel),
            .wdata_i (reg_wdata_i),
            .rdata_o (chan_rdata[n]),
            .alarm_o (alarm_o[n])
        );
    end

    // ------------------------------------------------------------
    // read data select
    // ------------------------------------------------------------
    always_comb begin
        sel_rdata = READ_UNMAPPED;
        for (int n = 0; n < NUM_CH; n++) begin
            if (dec.ch == CH_W'(n)) begin
                sel_rdata = chan_rdata[n];
            end
        end
    end

    // ------------------------------------------------------------
    // read answer register, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg  <= READ_UNMAPPED;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_rd_i;
            if (reg_rd_i) begin
                if (absent) begin
                    rdata_reg <= READ_ABSENT;
                end else if (dec.hit) begin
                    rdata_reg <= sel_rdata;
                end else begin
                    rdata_reg <= READ_UNMAPPED;    // not ours
                end
            end
        end
    end

    assign reg_rdata_o  = rdata_reg;
    assign reg_rvalid_o = rvalid_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [SEL_W-1:0] last_sel_reg;   // byte select of the last read, checks only
    logic             last_ok_reg;    // last read hit a built channel
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_sel_reg <= SEL_HTU;
            last_ok_reg  <= 1'b0;
        end else if (reg_rd_i) begin
            last_sel_reg <= dec.sel;
            last_ok_reg  <= dec.hit && !absent;
        end
    end

    sequence s_wr_ch0(logic [ADDR_W-1:0] a);
        reg_wr_i && reg_addr_i == a;
    endsequence
    sequence s_rd_only(logic [ADDR_W-1:0] a);
        reg_rd_i && !reg_wr_i && reg_addr_i == a;
    endsequence

    property p_reset_hyst;
        $fell(rst_i) |-> alarm_o[0].hyst == HYST_RST;
    endproperty
    a_reset_hyst: assert property (p_reset_hyst) else $error("hysteresis not zero after reset");

    property p_reset_upper;
        $fell(rst_i) |-> alarm_o[0].high_thr[THR_W-1:HYST_W] == HTU_RST;
    endproperty
    a_reset_upper: assert property (p_reset_upper) else $error("upper byte reset wrong");

    property p_reset_lower;
        $fell(rst_i) |-> alarm_o[0].high_thr[HYST_W-1:0] == HTL_RST;
    endproperty
    a_reset_lower: assert property (p_reset_lower) else $error("lower field reset wrong");

    property p_write_hyst;
        s_wr_ch0(CH0_HYST_ADDR) |=> alarm_o[0].hyst == $past(reg_wdata_i[DATA_W-1:FIELD_LSB]);
    endproperty
    a_write_hyst: assert property (p_write_hyst) else $error("hysteresis write lost");

    property p_write_upper;
        s_wr_ch0(CH0_HTU_ADDR) |=> alarm_o[0].high_thr[THR_W-1:HYST_W] == $past(reg_wdata_i);
    endproperty
    a_write_upper: assert property (p_write_upper) else $error("upper byte write lost");

    property p_write_lower;
        s_wr_ch0(CH0_HTL_ADDR) |=> alarm_o[0].high_thr[HYST_W-1:0] == $past(reg_wdata_i[DATA_W-1:FIELD_LSB]);
    endproperty
    a_write_lower: assert property (p_write_lower) else $error("lower field write lost");

    property p_low_bits_zero;
        reg_rvalid_o && last_ok_reg && last_sel_reg != SEL_HTU |-> reg_rdata_o[1:0] == LOW_BITS_ZERO;
    endproperty
    a_low_bits_zero: assert property (p_low_bits_zero) else $error("reserved bits read non-zero");

    property p_release;
        alarm_o[0].high_thr >= THR_W'(alarm_o[0].hyst)
            |-> alarm_o[0].high_release == alarm_o[0].high_thr - THR_W'(alarm_o[0].hyst);
    endproperty
    a_release: assert property (p_release) else $error("release level not threshold minus code");

    property p_absent_read;
        reg_rd_i && absent |=> reg_rdata_o == READ_ABSENT && reg_rvalid_o;
    endproperty
    a_absent_read: assert property (p_absent_read) else $error("absent channel not all ones");

    property p_readback_upper;
        s_wr_ch0(CH0_HTU_ADDR) ##1 s_rd_only(CH0_HTU_ADDR) |=> reg_rdata_o == $past(reg_wdata_i, 2);
    endproperty
    a_readback_upper: assert property (p_readback_upper) else $error("upper byte read-back wrong");

    // below the code the release point would wrap, so it sits at zero instead
    property p_release_floor;
        alarm_o[0].high_thr < THR_W'(alarm_o[0].hyst) |-> alarm_o[0].high_release == '0;
    endproperty
    a_release_floor: assert property (p_release_floor) else $error("release level not floored at zero");

    // read answer timing: valid follows the strobe by exactly one edge
    property p_rvalid_follows;
        reg_rd_i |=> reg_rvalid_o;
    endproperty
    a_rvalid_follows: assert property (p_rvalid_follows) else $error("read valid missing after strobe");

    property p_rvalid_pulse;
        !reg_rd_i |=> !reg_rvalid_o;
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without a strobe");

    // the answer byte stands until the next read, so a slow host can still take it
    property p_rdata_holds;
        !reg_rd_i |=> $stable(reg_rdata_o);
    endproperty
    a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved without a read");

    // any cycle without a channel 0 write must leave its settings alone
    sequence s_wr_ch0_any;
        reg_wr_i && dec.hit && dec.ch == '0;
    endsequence
    property p_other_keeps_ch0;
        not s_wr_ch0_any |=> $stable(alarm_o[0]);
    endproperty
    a_other_keeps_ch0: assert property (p_other_keeps_ch0) else $error("channel 0 changed without a write");

    property p_unmapped_read;
        reg_rd_i && !dec.hit |=> reg_rdata_o == READ_UNMAPPED;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped address read not zero");

endmodule

//--- test/ahthr_host_model.sv
`timescale 1ns/1ps
module ahthr_host_model
    import ahthr_pkg::*;
(
    // clock
    input  wire logic              clk_i,
    // register port toward the device
    output logic                   reg_wr_o,
    output logic                   reg_rd_o,
    output logic      [ADDR_W-1:0] reg_addr_o,
    output logic      [DATA_W-1:0] reg_wdata_o,
    // read answer from the device
    input  wire logic [DATA_W-1:0] reg_rdata_i,
    input  wire logic              reg_rvalid_i
);
    // ----------------------------------------
    // idle state and bus release
    // ----------------------------------------
    initial begin
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
    end

    // released lines flip, so a stale address or byte never passes for a held one
    task automatic release_bus();
        reg_addr_o  = ~reg_addr_o;
        reg_wdata_o = ~reg_wdata_o;
    endtask

    // ----------------------------------------
    // one-cycle strobes, launched just after an edge
    // ----------------------------------------
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        #1;
        reg_wr_o    = 1'b1;
        reg_addr_o  = a;
        reg_wdata_o = d;
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b0;
        release_bus();
    endtask

    // write, then read the same byte on the very next edge with address held
    task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
        @(posedge clk_i);
        #1;
        reg_wr_o    = 1'b1;
        reg_addr_o  = a;
        reg_wdata_o = d;
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        reg_rd_o = 1'b0;
        release_bus();
        q = reg_rdata_i;
    endtask

    // answer is taken one cycle after the strobe, while valid stands
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic ok);
        @(posedge clk_i);
        #1;
        reg_rd_o   = 1'b1;
        reg_addr_o = a;
        @(posedge clk_i);
        #1;
        reg_rd_o = 1'b0;
        release_bus();
        ok = reg_rvalid_i;
        d  = reg_rdata_i;
    endtask
endmodule

//--- test/alarm_high_threshold_hyst_regs_tb_top.sv
`timescale 1ns/1ps
module alarm_high_threshold_hyst_regs_tb_top;
    import ahthr_pkg::*;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic              clk;            // 200 MHz
    logic              rst;            // synchronous, active high
    logic              wr, rd;         // strobes from the host model
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata8, rdata4;
    logic              rvalid8, rvalid4, hit8, hit4;
    ahthr_alarm_t      alarm8 [MAX_CH];
    ahthr_alarm_t      alarm4 [4];
    logic [5:0]        e_hy [MAX_CH];  // expected settings per channel
    logic [7:0]        e_up [MAX_CH];
    logic [5:0]        e_lo [MAX_CH];
    int                fail_count = 0;
    int                num_checks = 0;
    int                cycles     = 0;
    int                codes [5]  = '{0, 1, 2, 62, 63};  // hysteresis end and inner codes
    logic [7:0]        q_rb;           // byte read straight after its write
    logic              hit8_seen;      // reg_hit_o as the last read was taken
    logic              hit4_seen;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------
    // full and small variant share one host
    // ----------------------------------------
    ahthr_host_model host (.clk_i(clk), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_rdata_i(rdata8), .reg_rvalid_i(rvalid8));
    ahthr_regs #(.NUM_CH(8)) dut (.clk_i(clk), .rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata8), .reg_rvalid_o(rvalid8),
        .reg_hit_o(hit8), .alarm_o(alarm8));
    ahthr_regs #(.NUM_CH(4)) dut4 (.clk_i(clk), .rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata4), .reg_rvalid_o(rvalid4),
        .reg_hit_o(hit4), .alarm_o(alarm4));

    // hit is combinational on the address, so catch it at the edge that takes the read
    always @(posedge clk) begin
        if (rd) begin
            hit8_seen <= hit8;
            hit4_seen <= hit4;
        end
    end

    // ----------------------------------------
    // compare and access tasks
    // ----------------------------------------
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic cmp_alarm(input ahthr_alarm_t got, input ahthr_alarm_t exp);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected alarm at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    // release level is the threshold less the code, floored at zero
    function automatic ahthr_alarm_t exp_alarm(input int ch);
        ahthr_alarm_t e;
        e.high_thr     = {e_up[ch], e_lo[ch]};
        e.hyst         = e_hy[ch];
        e.high_release = (e.high_thr > 14'(e_hy[ch])) ? e.high_thr - 14'(e_hy[ch]) : 14'h0000;
        return e;
    endfunction

    task automatic reset_model();
        for (int c = 0; c < MAX_CH; c++) begin
            e_hy[c] = HYST_RST;
            e_up[c] = HTU_RST;
            e_lo[c] = HTL_RST;
        end
    endtask

    task automatic wr_reg(input int ch, input int sel, input logic [7:0] d);
        host.wr(8'(CH0_HYST_ADDR + ch * CH_STRIDE + sel), d);
        if (sel == 0) e_hy[ch] = d[7:2];
        if (sel == 1) e_up[ch] = d;
        if (sel == 2) e_lo[ch] = d[7:2];
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp8, input logic [7:0] exp4);
        logic [7:0] d;
        logic       ok;
        logic       eh;
        // our bytes are the first three of each five-byte set, absent channels included
        eh = (a >= CH0_HYST_ADDR) && (a < MAP_END) && (((a - CH0_HYST_ADDR) % CH_STRIDE) < 8'h03);
        host.rd(a, d, ok);
        cmp_byte({7'h00, ok}, 8'h01);
        cmp_byte({7'h00, rvalid4}, 8'h01);
        cmp_byte({7'h00, hit8_seen}, {7'h00, eh});
        cmp_byte({7'h00, hit4_seen}, {7'h00, eh});
        cmp_byte(d, exp8);
        cmp_byte(rdata4, exp4);
    endtask

    // every byte and every alarm output of both variants against the model
    task automatic check_all();
        logic [7:0] e;
        for (int c = 0; c < MAX_CH; c++) begin
            for (int s = 0; s < 3; s++) begin
                e = (s == 0) ? {e_hy[c], 2'b00} : (s == 1) ? e_up[c] : {e_lo[c], 2'b00};
                rd_chk(8'(CH0_HYST_ADDR + c * CH_STRIDE + s), e, (c < 4) ? e : READ_ABSENT);
            end
            cmp_alarm(alarm8[c], exp_alarm(c));
            if (c < 4) cmp_alarm(alarm4[c], exp_alarm(c));
        end
    endtask

    task automatic finish_test();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // hang guard, well above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        reset_model();
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        check_all();
        // hysteresis end and inner codes, low bits written as ones
        foreach (codes[i]) begin
            wr_reg(0, 0, {codes[i][5:0], 2'b11});
            cmp_alarm(alarm8[0], exp_alarm(0));
            rd_chk(CH0_HYST_ADDR, {codes[i][5:0], 2'b00}, {codes[i][5:0], 2'b00});
        end
        // threshold of one under the largest code floors the release level
        wr_reg(0, 1, 8'h00);
        wr_reg(0, 2, 8'h07);
        cmp_alarm(alarm8[0], exp_alarm(0));
        wr_reg(0, 1, 8'hff);
        cmp_byte(alarm8[0].high_thr[13:6], 8'hff);
        wr_reg(0, 1, 8'haa);
        wr_reg(0, 2, 8'hff);
        cmp_alarm(alarm8[0], '{14'h2abf, 6'h3f, 14'h2a80});
        // a read on the edge right after a write already returns the new byte
        host.wr_rd(CH0_HTU_ADDR, 8'h5c, q_rb);
        e_up[0] = 8'h5c;
        cmp_byte(q_rb, 8'h5c);
        cmp_alarm(alarm8[0], exp_alarm(0));
        // distinct values in every channel expose address aliasing
        for (int c = 0; c < MAX_CH; c++) begin
            wr_reg(c, 0, 8'(8 * c + 4));
            wr_reg(c, 1, 8'(8'h10 + c));
            wr_reg(c, 2, 8'(8'hf0 - 4 * c));
        end
        check_all();
        // low threshold bytes and addresses outside the map are ignored
        host.wr(8'h18, 8'h5a);
        host.wr(8'h14, 8'h5a);
        rd_chk(8'h18, READ_UNMAPPED, READ_UNMAPPED);
        rd_chk(8'h14, READ_UNMAPPED, READ_UNMAPPED);
        rd_chk(MAP_END, READ_UNMAPPED, READ_UNMAPPED);
        check_all();
        // second reset in mid-run restores the printed defaults
        @(posedge clk);
        #1 rst = 1'b1;
        reset_model();
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        check_all();
        finish_test();
    end
endmodule
